//--- design/swc_top.sv
// Stop recovery, reset delay and supply monitor logic
module swc_top #(
  parameter int DELAY_CYCLES = swc_pkg::SWC_DELAY_CYCLES,
  parameter int VALID_CYCLES = swc_pkg::SWC_VALID_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic rc_tick,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire swc_pkg::swc_core_in_type core_in,
  input wire logic [3:0] port3_in,
  input wire logic [7:0] port2_in,
  input wire logic [7:0] port2_is_output,
  input wire logic vcc_above_high,
  input wire logic vcc_below_low,
  input wire logic req_five_clear,
  input wire logic req_five_mask,
  output logic cpu_clk_en,
  output logic osc_en,
  output logic cpu_hold,
  output logic restart_pulse,
  output logic [15:0] restart_addr,
  output logic interrupt_request_five,
  output logic req_five_active,
  output logic low_supply_flag,
  output logic high_supply_flag
);
  import swc_pkg::*;

  typedef struct packed {
    swc_mode_type mode;
    logic [7:0] wake_ctl;
    logic supply_monitor_enable;
    logic low_flag;
    logic high_flag;
    logic [31:0] delay_cnt;
    logic [31:0] valid_cnt;
    logic [2:0] fast_cnt;
    logic req_five;
    logic req_five_out;
    logic [7:0] rdata;
    logic cpu_clk_en;
    logic osc_en;
    logic hold;
    logic restart;
    logic [15:0] rst_addr;
  } swc_state_type;

  swc_state_type st;
  swc_state_type next_st;
  logic [7:0] p2_term;
  logic src_raw;
  logic wake_hit;
  logic flags_valid;

  // ----------------------------------------
  // Wake source select
  // ----------------------------------------
  // Port 2 pins driven as outputs read as low (0) so they drop out of the NOR
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_p2
      assign p2_term[gi] = port2_is_output[gi] ? 1'b0 : port2_in[gi]; // RL10
    end
  endgenerate

  // Combinational path: pins need no clock to be seen
  always_comb begin // RL9 RL23
    case (st.wake_ctl[SWC_SRC_LSB +: 3])
      SWC_SRC_PORT3_BIT1: src_raw = port3_in[1];
      SWC_SRC_PORT3_BIT2: src_raw = port3_in[2];
      SWC_SRC_PORT3_BIT3: src_raw = port3_in[3];
      SWC_SRC_PORT2_BIT7: src_raw = port2_in[7];
      SWC_SRC_NOR4: src_raw = ~|p2_term[3:0];
      SWC_SRC_NOR8: src_raw = ~|p2_term;
      default: src_raw = ~st.wake_ctl[SWC_BIT_LEVEL];
    endcase
    wake_hit = (src_raw == st.wake_ctl[SWC_BIT_LEVEL]); // RL14
  end

  assign flags_valid = st.valid_cnt >= 32'(VALID_CYCLES);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.restart = 1'b0;
    // Register writes; reserved and read-only bits ignored
    if (reg_wr && reg_addr == SWC_ADDR_WAKE) begin
      next_st.wake_ctl[6:0] = reg_wdata[6:0]; // RL15
    end
    if (reg_wr && reg_addr == SWC_ADDR_SUPPLY) begin
      next_st.supply_monitor_enable = reg_wdata[SWC_BIT_MON_EN]; // RL16 RL18
    end
    // Flag settle counter restarts on each enable
    if (!next_st.supply_monitor_enable) begin
      next_st.valid_cnt = '0;
    end else if (!flags_valid) begin
      next_st.valid_cnt = st.valid_cnt + 32'd1;
    end
    next_st.high_flag = st.supply_monitor_enable && flags_valid && vcc_above_high; // RL17
    next_st.low_flag = st.supply_monitor_enable && flags_valid && vcc_below_low; // RL18
    // Set wins over software clear
    if (req_five_clear) begin
      next_st.req_five = 1'b0;
    end
    if (st.low_flag && st.supply_monitor_enable) begin
      next_st.req_five = 1'b1; // RL19
    end
    next_st.req_five_out = next_st.req_five & req_five_mask; // RL19
    // Power mode sequencing
    case (st.mode)
      SWC_RUN: begin
        if (core_in.stop_req) begin
          next_st.mode = SWC_STOP; // RL6
          // A count left from an earlier wake would shorten the hold
          next_st.fast_cnt = '0; // RL12
        end else if (core_in.halt_req) begin
          next_st.mode = SWC_HALT; // RL4
        end
      end
      SWC_HALT: begin
        if (core_in.irq_taken) begin
          next_st.mode = SWC_RUN; // RL5
        end
      end
      SWC_STOP: begin
        // Fast wake needs source held; delay path starts at once
        if (wake_hit && st.wake_ctl[SWC_SRC_LSB +: 3] != SWC_SRC_RESET_ONLY) begin
          next_st.wake_ctl[SWC_BIT_WARM] = 1'b1; // RL15
          if (st.wake_ctl[SWC_BIT_DELAY]) begin
            next_st.mode = SWC_DELAY; // RL1 RL11
            next_st.delay_cnt = '0;
          end else if (st.fast_cnt == 3'(SWC_FAST_HOLD - 1)) begin
            next_st.mode = SWC_RUN; // RL11 RL7
            next_st.restart = 1'b1;
          end else begin
            next_st.fast_cnt = st.fast_cnt + 3'd1;
          end
        end else begin
          next_st.fast_cnt = '0;
        end
      end
      SWC_DELAY: begin
        if (rc_tick) begin
          next_st.delay_cnt = st.delay_cnt + 32'd1; // RL3
        end
        if (st.delay_cnt >= 32'(DELAY_CYCLES)) begin
          next_st.mode = SWC_RUN; // RL2 RL7
          next_st.restart = 1'b1;
        end
      end
      default: next_st.mode = SWC_RUN;
    endcase
    // Other resets restart the one-shot and clear warm start
    if (core_in.watchdog_timeout || !core_in.power_good || core_in.ext_reset) begin
      next_st.mode = SWC_DELAY; // RL1 RL7
      next_st.restart = 1'b0;
      next_st.delay_cnt = '0;
      next_st.wake_ctl[SWC_BIT_WARM] = 1'b0; // RL15
      next_st.fast_cnt = '0;
    end
    if (next_st.mode == SWC_STOP) begin
      next_st.supply_monitor_enable = 1'b0;
    end
    next_st.cpu_clk_en = next_st.mode == SWC_RUN; // RL4 RL6
    next_st.osc_en = next_st.mode != SWC_STOP; // RL4 RL6
    next_st.hold = next_st.mode == SWC_DELAY; // RL3
    next_st.rst_addr = SWC_RESTART_VECTOR; // RL7
    // Read data, one cycle after strobe
    next_st.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        SWC_ADDR_WAKE: next_st.rdata = st.wake_ctl;
        SWC_ADDR_SUPPLY: begin
          next_st.rdata = {5'h00, st.high_flag, st.low_flag, st.supply_monitor_enable};
        end
        SWC_ADDR_STATUS: next_st.rdata = {7'h00, st.req_five};
        default: next_st.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
      st.mode <= SWC_DELAY; // RL1
      st.wake_ctl <= SWC_WAKE_RESET; // RL11 RL14
      st.hold <= 1'b1;
      st.osc_en <= 1'b1;
      st.rst_addr <= SWC_RESTART_VECTOR;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign cpu_clk_en = st.cpu_clk_en;
  assign osc_en = st.osc_en;
  assign cpu_hold = st.hold;
  assign restart_pulse = st.restart;
  assign restart_addr = st.rst_addr;
  assign interrupt_request_five = st.req_five;
  assign req_five_active = st.req_five_out;
  assign low_supply_flag = st.low_flag;
  assign high_supply_flag = st.high_flag;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_stop_osc;
    @(posedge clk_sys) disable iff (!rst_n) st.mode == SWC_STOP |-> !osc_en && !cpu_clk_en;
  endproperty
  a_stop_osc: assert property (p_stop_osc) else $error("oscillator on in stop"); // RL6
  property p_halt_clk;
    @(posedge clk_sys) disable iff (!rst_n) st.mode == SWC_HALT |-> osc_en && !cpu_clk_en;
  endproperty
  a_halt_clk: assert property (p_halt_clk) else $error("halt clocks wrong"); // RL4
  property p_halt_exit;
    @(posedge clk_sys) disable iff (!rst_n)
      st.mode == SWC_HALT && !core_in.irq_taken && core_in.power_good && !core_in.watchdog_timeout
      && !core_in.ext_reset |=> st.mode == SWC_HALT;
  endproperty
  a_halt_exit: assert property (p_halt_exit) else $error("halt left without irq"); // RL5
  property p_hold;
    @(posedge clk_sys) disable iff (!rst_n) st.mode == SWC_DELAY |-> cpu_hold && !cpu_clk_en;
  endproperty
  a_hold: assert property (p_hold) else $error("execution not held"); // RL3
  property p_delay_len;
    @(posedge clk_sys) disable iff (!rst_n)
      $fell(cpu_hold) |-> $past(st.delay_cnt) >= 32'(DELAY_CYCLES);
  endproperty
  a_delay_len: assert property (p_delay_len) else $error("delay too short"); // RL2
  property p_vector;
    @(posedge clk_sys) disable iff (!rst_n) restart_pulse |-> restart_addr == 16'h000c;
  endproperty
  a_vector: assert property (p_vector) else $error("bad restart vector"); // RL7
  property p_req_five;
    @(posedge clk_sys) disable iff (!rst_n)
      low_supply_flag && st.supply_monitor_enable |=> interrupt_request_five;
  endproperty
  a_req_five: assert property (p_req_five) else $error("request five not set"); // RL19
  property p_flag_valid;
    @(posedge clk_sys) disable iff (!rst_n) !flags_valid |=> !low_supply_flag && !high_supply_flag;
  endproperty
  a_flag_valid: assert property (p_flag_valid) else $error("flag before settle"); // RL16
  property p_warm;
    @(posedge clk_sys) disable iff (!rst_n) core_in.watchdog_timeout |=> !st.wake_ctl[SWC_BIT_WARM];
  endproperty
  a_warm: assert property (p_warm) else $error("warm bit kept"); // RL15
  // Active request needs both the latch and the mask of the cycle before
  property p_req_mask;
    @(posedge clk_sys) disable iff (!rst_n)
      req_five_active |-> interrupt_request_five && $past(req_five_mask);
  endproperty
  a_req_mask: assert property (p_req_mask) else $error("request passed the mask"); // RL19
  property p_stop_entry;
    @(posedge clk_sys) disable iff (!rst_n)
      st.mode == SWC_RUN && core_in.stop_req && core_in.power_good
      && !core_in.watchdog_timeout && !core_in.ext_reset |=> st.mode == SWC_STOP;
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("stop request ignored"); // RL6
  // Reset-only source must never wake the part by itself
  property p_reset_only;
    @(posedge clk_sys) disable iff (!rst_n)
      st.mode == SWC_STOP && st.wake_ctl[SWC_SRC_LSB +: 3] == SWC_SRC_RESET_ONLY
      && core_in.power_good && !core_in.watchdog_timeout && !core_in.ext_reset
      |=> st.mode == SWC_STOP;
  endproperty
  a_reset_only: assert property (p_reset_only) else $error("stop left without reset"); // RL7 RL9
  property p_warm_set;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(st.wake_ctl[SWC_BIT_WARM]) |-> $past(st.mode) == SWC_STOP;
  endproperty
  a_warm_set: assert property (p_warm_set) else $error("warm bit set outside recovery"); // RL15
  // Monitor cannot run without the oscillator, so stop turns it off
  property p_monitor_stop;
    @(posedge clk_sys) disable iff (!rst_n) st.mode == SWC_STOP |-> !st.supply_monitor_enable;
  endproperty
  a_monitor_stop: assert property (p_monitor_stop) else $error("monitor on in stop"); // RL16
  property p_restart_run;
    @(posedge clk_sys) disable iff (!rst_n) restart_pulse |-> cpu_clk_en && !cpu_hold;
  endproperty
  a_restart_run: assert property (p_restart_run) else $error("restart while held"); // RL7
  c_stop: cover property (@(posedge clk_sys) st.mode == SWC_STOP);
  c_fast: cover property (@(posedge clk_sys) st.mode == SWC_STOP ##1 restart_pulse);
  c_halt: cover property (@(posedge clk_sys) st.mode == SWC_HALT ##1 st.mode == SWC_RUN);
  c_delay: cover property (@(posedge clk_sys) st.mode == SWC_STOP ##1 st.mode == SWC_DELAY);
endmodule

//--- design/swc_pkg.sv
// Package for the stop recovery and supply monitor block
//
// Overview of operation
// RL1: Delay timer one-shot: power-good, recovery, watchdog.
// RL2: Reset delay lasts at least 2.5 ms.
// RL3: Delay tick from own RC; execution held.
// RL4: Halt gates CPU clock, oscillator keeps running.
// RL5: Halt exits only on taken enabled interrupt.
// RL6: Stop halts CPU clock and oscillator.
// RL7: Stop exits only by reset, vector 000c.
// RL8: Software issues no-op before stop or halt.
// RL9: Source field selects wake pin or NOR.
// RL10: Port 2 outputs drop out of NOR.
// RL11: Delay bit resets to one; zero skips delay.
// RL12: Fast wake source held five clock periods.
// RL13: Keep delay bit set with crystal clocks.
// RL14: Level bit picks wake polarity, resets zero.
// RL15: Warm-start bit read-only, set by recovery.
// RL16: Monitor enable bit; flags valid after 20 us.
// RL17: High flag read-only, above high threshold.
// RL18: Low flag read-only; bits 7..3 ignored.
// RL19: Low flag latches request five, mask gated.
// RL20: Software disables monitor before stop.
// RL21: Software leaves port mode register alone.
// RL22: Software enables interrupts before monitor.
// RL23: Wake detection works without running clock.
package swc_pkg;
  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [7:0] SWC_ADDR_SUPPLY = 8'h0c;
  localparam logic [7:0] SWC_ADDR_WAKE = 8'h0b;
  localparam logic [7:0] SWC_ADDR_STATUS = 8'h0e;
  localparam int SWC_BIT_DELAY = 5;
  localparam int SWC_BIT_LEVEL = 6;
  localparam int SWC_BIT_WARM = 7;
  localparam int SWC_SRC_LSB = 2;
  localparam int SWC_BIT_MON_EN = 0;
  localparam int SWC_BIT_LOW = 1;
  localparam int SWC_BIT_HIGH = 2;
  localparam logic [7:0] SWC_WAKE_RESET = 8'h20;
  localparam logic [2:0] SWC_SRC_RESET_ONLY = 3'h0;
  localparam logic [2:0] SWC_SRC_PORT3_BIT1 = 3'h2;
  localparam logic [2:0] SWC_SRC_PORT3_BIT2 = 3'h3;
  localparam logic [2:0] SWC_SRC_PORT3_BIT3 = 3'h4;
  localparam logic [2:0] SWC_SRC_PORT2_BIT7 = 3'h5;
  localparam logic [2:0] SWC_SRC_NOR4 = 3'h6;
  localparam logic [2:0] SWC_SRC_NOR8 = 3'h7;
  localparam logic [15:0] SWC_RESTART_VECTOR = 16'h000c;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int SWC_CLK_MHZ = 250;
  localparam int SWC_DELAY_US_X10 = 25000;
  localparam int SWC_DELAY_CYCLES = (SWC_DELAY_US_X10 * SWC_CLK_MHZ + 9) / 10;
  localparam int SWC_VALID_US = 20;
  localparam int SWC_VALID_CYCLES = SWC_VALID_US * SWC_CLK_MHZ;
  localparam int SWC_FAST_HOLD = 5;
  typedef enum {SWC_RUN, SWC_HALT, SWC_STOP, SWC_DELAY} swc_mode_type;
  // Core-side power requests
  typedef struct packed {
    logic halt_req;
    logic stop_req;
    logic irq_taken;
    logic watchdog_timeout;
    logic power_good;
    logic ext_reset;
  } swc_core_in_type;
endpackage

//--- dv/swc_wake_pins.sv
// Wake pin model standing in for the external port 3 pins
module swc_wake_pins #(
  parameter int HOLD = 6
) (
  input wire logic clk_sys,
  input wire logic go,
  input wire logic lvl,
  output logic [3:0] port3_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // Source held active for HOLD periods, six by default, one more than the five needed
  always @(posedge clk_sys) begin
    if (go) begin
      cnt <= HOLD;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  // Idle pins sit at the inactive level so no stray wake is seen
  assign port3_in = {~lvl, ~lvl, (cnt > 0) ? lvl : ~lvl, ~lvl};
endmodule

//--- dv/swc_top_test.sv
// Self-checking bench for the stop recovery and supply monitor
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
  $display("Error %0t: got %h exp %h", $time, a, b); end end
module swc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import swc_pkg::*;
  localparam int DLY = 20;
  localparam int VLD = 10;
  logic clk_sys = 1'h0, rst_n = 1'h0, rc_tick = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, port2_in = 8'h00;
  logic [7:0] port2_is_output = 8'h00, reg_rdata, e;
  logic vcc_above_high = 1'h0, vcc_below_low = 1'h0, req_five_clear = 1'h0, req_five_mask = 1'h0;
  logic go = 1'h0, lvl = 1'h1, rnd_on = 1'h1, rd_d = 1'h0;
  swc_core_in_type core_in = '{power_good: 1'h1, default: 1'h0};
  logic [3:0] port3_in;
  logic cpu_clk_en, osc_en, cpu_hold, restart_pulse, interrupt_request_five;
  logic req_five_active, low_supply_flag, high_supply_flag;
  logic [15:0] restart_addr;
  logic [7:0] exp_q[$];
  int fail_count = 0, compares = 0, seed = 33043, n;

  swc_top #(.DELAY_CYCLES(DLY), .VALID_CYCLES(VLD)) u_dut (.clk_sys, .rst_n, .rc_tick,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .core_in, .port3_in, .port2_in,
    .port2_is_output, .vcc_above_high, .vcc_below_low, .req_five_clear, .req_five_mask,
    .cpu_clk_en, .osc_en, .cpu_hold, .restart_pulse, .restart_addr, .interrupt_request_five,
    .req_five_active,
    .low_supply_flag, .high_supply_flag);
  swc_wake_pins u_pins (.clk_sys, .go, .lvl, .port3_in);

  // ----------------------------------------
  // Clock, RC tick and port 2 noise
  // ----------------------------------------
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    rc_tick <= ~rc_tick;
    if (rnd_on) begin
      port2_in <= $random(seed);
      port2_is_output <= $random(seed);
    end
  end
  // Read data stands only in the cycle after the strobe
  always @(posedge clk_sys) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      e = exp_q.pop_front();
      `CHK(reg_rdata, e)
    end
  end
  // ----------------------------------------
  // Bus tasks and helpers
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'h1;
    exp_q.push_back(x);
    @(posedge clk_sys);
    reg_rd <= 1'h0;
  endtask
  // Bounded wait so a missing restart cannot hang the run
  task automatic wait_restart(output int k);
    k = 0;
    while (restart_pulse !== 1'h1 && k < 400) begin
      @(negedge clk_sys);
      k++;
    end
    if (k >= 400) fail_count++;
  endtask
  task automatic pulse_core(input int which);
    @(posedge clk_sys);
    // Core has flushed its pipeline with a no-op before any sleep request
    if (which == 0) core_in.stop_req <= 1'h1;
    if (which == 1) core_in.watchdog_timeout <= 1'h1;
    if (which == 2) core_in.halt_req <= 1'h1;
    if (which == 3) core_in.irq_taken <= 1'h1;
    if (which == 4) core_in.ext_reset <= 1'h1;
    if (which == 5) core_in.power_good <= 1'h0;
    @(posedge clk_sys);
    core_in <= '{power_good: 1'h1, default: 1'h0};
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic end_of_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog sized well past the expected run length
  initial begin
    #20000;
    fail_count++;
    end_of_test();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'h1;
    wait_restart(n);
    `CHK(n >= 2 * DLY - 2, 1'b1)
    `CHK(restart_addr, SWC_RESTART_VECTOR)
    rd(SWC_ADDR_WAKE, SWC_WAKE_RESET);
    rd(SWC_ADDR_SUPPLY, 8'h00);
    rd(8'h3f, 8'h00);
    vcc_below_low <= 1'h1;
    wr(SWC_ADDR_SUPPLY, 8'hff);
    @(negedge clk_sys);
    `CHK(low_supply_flag, 1'b0)
    repeat (VLD + 4) @(negedge clk_sys);
    `CHK(interrupt_request_five, 1'b1)
    `CHK(req_five_active, 1'b0)
    @(posedge clk_sys);
    req_five_mask <= 1'h1;
    repeat (2) @(negedge clk_sys);
    `CHK(req_five_active, 1'b1)
    rd(SWC_ADDR_SUPPLY, 8'h03);
    rd(SWC_ADDR_STATUS, 8'h01);
    vcc_below_low <= 1'h0;
    vcc_above_high <= 1'h1;
    repeat (4) @(posedge clk_sys);
    req_five_clear <= 1'h1;
    @(posedge clk_sys);
    req_five_clear <= 1'h0;
    repeat (2) @(negedge clk_sys);
    `CHK({interrupt_request_five, high_supply_flag}, 2'b01)
    rd(SWC_ADDR_STATUS, 8'h00);
    // Port 2 mode is rewritten at random every clock while the low flag is watched
    wr(SWC_ADDR_SUPPLY, 8'h00);
    // Fast wake from a high level on port 3 bit 1
    wr(SWC_ADDR_WAKE, 8'h48);
    pulse_core(0);
    `CHK({osc_en, cpu_clk_en}, 2'b00)
    @(posedge clk_sys);
    go <= 1'h1;
    @(posedge clk_sys);
    go <= 1'h0;
    wait_restart(n);
    `CHK(n <= 12, 1'b1)
    rd(SWC_ADDR_WAKE, 8'hc8);
    // Delayed wake, NOR of low nibble with an output bit dropping out
    rnd_on <= 1'h0;
    @(posedge clk_sys);
    port2_in <= 8'h01;
    port2_is_output <= 8'h00;
    wr(SWC_ADDR_WAKE, 8'h78);
    pulse_core(0);
    repeat (6) @(negedge clk_sys);
    `CHK(osc_en, 1'b0)
    @(posedge clk_sys);
    port2_is_output <= 8'h01;
    wait_restart(n);
    `CHK(n >= 2 * DLY - 2, 1'b1)
    rd(SWC_ADDR_WAKE, 8'hf8);
    pulse_core(1);
    wait_restart(n);
    `CHK(n >= 2 * DLY - 4, 1'b1)
    rd(SWC_ADDR_WAKE, 8'h78);
    // External reset and power fail both rerun the one-shot
    for (int w = 4; w < 6; w++) begin
      pulse_core(w);
      wait_restart(n);
      `CHK(n >= 2 * DLY - 4, 1'b1)
    end
    for (int s = 0; s < 8; s++) begin
      wr(SWC_ADDR_WAKE, 8'h80 | 8'(s << 2));
      rd(SWC_ADDR_WAKE, 8'(s << 2));
    end
    // Reset-only source: stop is left only through a reset, here the watchdog
    wr(SWC_ADDR_WAKE, SWC_WAKE_RESET);
    pulse_core(0);
    repeat (8) @(negedge clk_sys);
    `CHK(osc_en, 1'b0)
    pulse_core(1);
    wait_restart(n);
    `CHK(restart_addr, SWC_RESTART_VECTOR)
    // Halt keeps the oscillator and leaves only on a taken interrupt
    pulse_core(2);
    repeat (3) @(negedge clk_sys);
    `CHK({cpu_clk_en, osc_en}, 2'b01)
    pulse_core(3);
    `CHK(cpu_clk_en, 1'b1)
    end_of_test();
  end
endmodule
